// ==== uiohps_pkg.sv ====
/*
 * Shared constants, enumerations and carrier structs for the user I/O
 * and host port select block.
 * Assumes a single 50 MHz system clock; the cycle counts below derive from it.
 */
package uiohps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned MIN_PULSE_MS = 3;
    // Least time, so round up
    localparam int unsigned MIN_PULSE_CYC =
        (MIN_PULSE_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RS485_BAUD = 115200;
    localparam int unsigned BAUD_DIV = CLK_HZ / RS485_BAUD;
    localparam int unsigned BAUD_CW = 9;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int unsigned N_DIN = 4;
    localparam int unsigned N_DOUT = 8;
    localparam int unsigned N_FN = 8;
    localparam int unsigned N_STV = 16;
    localparam int unsigned N_PORT = 5;
    localparam int unsigned USB_FRONT_BIT = 0;
    localparam int unsigned USB_REAR_BIT = 1;
    localparam logic [N_PORT-1:0] GRANT_RST = 5'h01;

    ////////////////////////////////////////////////////////////////////////
    // Enumerations
    typedef enum logic [2:0] {
        FN_NONE,
        FN_START,
        FN_STOP,
        FN_INPUT_ENABLE,
        FN_INTERLOCK,
        FN_CLEAR,
        FN_LOCK
    } uiohps_fn_e;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_ENABLED,
        ST_STANDBY_OR_FAULT,
        ST_STANDBY,
        ST_FAULT,
        ST_VOLTAGE_REGULATING_STATE,
        ST_CURRENT_REGULATING_STATE,
        ST_POWER_REGULATING_STATE,
        ST_RESISTANCE_REGULATING_STATE,
        ST_LOCKED
    } uiohps_st_e;

    typedef enum logic [2:0] {
        RS485_INDICATION,
        FRONT_USB_INDICATION,
        REAR_USB_INDICATION,
        ETHERNET_INDICATION,
        GPIB_INDICATION
    } uiohps_port_e;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic processing;
        logic fault_cond;
        logic voltage_regulating_state;
        logic current_regulating_state;
        logic power_regulating_state;
        logic resistance_regulating_state;
    } uiohps_plant_s;

    typedef struct packed {
        logic front_usb_attach;
        logic rear_usb_attach;
        logic eth_cmd;
        logic gpib_cmd;
    } uiohps_host_s;

endpackage

// ==== uiohps_in_filt.sv ====
/*
 * One digital input: two-stage synchroniser and a persistence filter.
 * Assumes din is asynchronous; lvl follows din only after the new level
 * has held for MIN_CYC consecutive clocks.
 */
module uiohps_in_filt
    import uiohps_pkg::*;
#(
    parameter int unsigned MIN_CYC = MIN_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pin and filtered level
    input wire logic din,
    output logic lvl
);

    localparam int unsigned CW = $clog2(MIN_CYC + 1);

    generate
        if (MIN_CYC < 2) begin : g_bad
            $error("MIN_CYC must be at least 2");
        end
    endgenerate

    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic [CW-1:0] cnt;
    } uiohps_filt_s;

    uiohps_filt_s q;
    uiohps_filt_s d;

    ////////////////////////////////////////////////////////////////////////
    // Symmetric filter: short lows on an interlock are also ignored
    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
        if (q.s2 == q.lvl) begin
            d.cnt = '0;
        end else if (q.cnt == CW'(MIN_CYC - 1)) begin // [RQ23]
            d.lvl = q.s2; // [RQ2]
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lvl = q.lvl;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    filt_hold_a: assert property ($changed(q.lvl) |-> $past(q.cnt) == CW'(MIN_CYC - 1)) // [RQ23]
        else $error("filtered level moved before the hold time");
    filt_rst_a: assert property (q.s2 == q.lvl |=> q.cnt == '0) // [RQ2]
        else $error("filter count not restarted on agreement");

endmodule

// ==== uiohps_top.sv ====
/*
 * User I/O and host port select: digital input functions, eight
 * assignable status outputs, and the host command bus arbiter.
 * Assumes din_pin and USB attach are asynchronous pins; all other inputs
 * come from logic on clk.
 */

// How it works
// [RQ1] Stop beats start in the same cycle
// [RQ2] Momentary functions fire on filtered rising edge
// [RQ3] Normally-closed function trips when high goes away
// [RQ4] Present functions active while pin stays high
// [RQ5] Input enable high runs, low stops
// [RQ6] Interlock pin low means interlock trip
// [RQ7] Clear removes fault only once condition gone
// [RQ8] Lock blocks front-panel key presses
// [RQ9] Output pin high while selected state active
// [RQ10] Eight outputs, each picks one of nine states
// [RQ11] Enabled means running and processing power
// [RQ12] Standby-or-fault is OR of both
// [RQ13] Regulation states follow the regulated quantity
// [RQ14] Locked state follows active lock function
// [RQ15] Exactly one port owns bus, always reported
// [RQ16] Front USB, rear USB, Ethernet/GPIB, then RS485
// [RQ17] USB attach takes bus at once
// [RQ18] Ethernet or GPIB command takes bus
// [RQ19] USB regains bus only on reattach or reset
// [RQ20] RS485 owns bus by default, lowest priority
// [RQ21] Indication shows front or rear USB code
// [RQ22] RS485 bit tick at fixed baud rate
// [RQ23] Inputs synchronised, short highs filtered out
module uiohps_top
    import uiohps_pkg::*;
#(
    parameter int unsigned NUM_DIN = N_DIN,
    parameter int unsigned NUM_DOUT = N_DOUT,
    parameter int unsigned MIN_CYC = MIN_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // User I/O pins
    input wire logic [NUM_DIN-1:0] din_pin,
    output logic [NUM_DOUT-1:0] dout_pin,
    // Pin assignment
    input wire uiohps_fn_e [NUM_DIN-1:0] din_fn,
    input wire uiohps_st_e [NUM_DOUT-1:0] dout_sel,
    // Power stage
    input wire uiohps_plant_s plant,
    input wire logic start_cmd,
    input wire logic stop_cmd,
    output logic run_req,
    output logic fault_latched,
    output logic interlock_trip,
    output logic panel_locked,
    // Front panel keys
    input wire logic key_press,
    output logic key_accept,
    // Host ports
    input wire uiohps_host_s host,
    output uiohps_port_e active_port,
    output logic [N_PORT-1:0] port_grant,
    output logic rs485_bit_tick
);

    generate
        if (NUM_DIN < 1 || NUM_DOUT < 1 || MIN_CYC < 2) begin : g_bad
            $error("unsupported parameter values");
        end
    endgenerate

    typedef struct packed {
        logic [NUM_DIN-1:0] din_prev;
        logic [1:0] usb_s1;
        logic [1:0] usb_s2;
        logic [1:0] usb_prev;
        logic run;
        logic fault;
        logic trip;
        logic lock;
        logic key_acc;
        logic [NUM_DOUT-1:0] dout;
        uiohps_port_e owner;
        logic [N_PORT-1:0] grant;
        logic [BAUD_CW-1:0] baud_cnt;
        logic baud_tick;
    } uiohps_state_s;

    uiohps_state_s q;
    uiohps_state_s d;
    logic [NUM_DIN-1:0] din_lvl;
    logic [N_FN-1:0] fn_asg;
    logic [N_FN-1:0] fn_lvl;
    logic [N_FN-1:0] fn_low;
    logic [N_FN-1:0] fn_rise;
    logic [N_STV-1:0] stv;
    logic start_ev;
    logic stop_ev;
    logic flt_set;
    logic f_rise;
    logic r_rise;

    ////////////////////////////////////////////////////////////////////////
    // Input conditioning
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DIN; gi++) begin : g_din
            uiohps_in_filt #(
                .MIN_CYC(MIN_CYC)
            ) u_filt (
                .clk(clk),
                .nrst(nrst),
                .din(din_pin[gi]),
                .lvl(din_lvl[gi]) // [RQ23]
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        fn_asg = '0;
        fn_lvl = '0;
        fn_low = '0;
        fn_rise = '0;
        // Several pins on one function are ORed
        for (int i = 0; i < NUM_DIN; i++) begin
            fn_asg[din_fn[i]] = 1'b1;
            if (din_lvl[i]) begin
                fn_lvl[din_fn[i]] = 1'b1; // [RQ4]
            end else begin
                fn_low[din_fn[i]] = 1'b1;
            end
            if (din_lvl[i] && !q.din_prev[i]) begin
                fn_rise[din_fn[i]] = 1'b1; // [RQ2]
            end
        end
        d.din_prev = din_lvl;

        start_ev = start_cmd || fn_rise[FN_START];
        stop_ev = stop_cmd || fn_rise[FN_STOP];
        // Unassigned interlock never trips
        d.trip = fn_low[FN_INTERLOCK]; // [RQ3] [RQ6]

        // Set wins over clear
        flt_set = plant.fault_cond || d.trip;
        if (flt_set) begin
            d.fault = 1'b1;
        end else if (fn_lvl[FN_CLEAR]) begin
            d.fault = 1'b0; // [RQ7]
        end

        if (stop_ev || d.trip || q.fault) begin
            d.run = 1'b0; // [RQ1]
        end else if (fn_asg[FN_INPUT_ENABLE]) begin
            d.run = fn_lvl[FN_INPUT_ENABLE]; // [RQ5]
        end else if (start_ev) begin
            d.run = 1'b1;
        end

        d.lock = fn_lvl[FN_LOCK]; // [RQ4]
        d.key_acc = key_press && !fn_lvl[FN_LOCK]; // [RQ8]

        // Codes past the ninth state read low
        stv = '0;
        stv[ST_ENABLED] = q.run && plant.processing; // [RQ11]
        stv[ST_STANDBY] = !q.run;
        stv[ST_FAULT] = q.fault;
        stv[ST_STANDBY_OR_FAULT] = !q.run || q.fault; // [RQ12]
        stv[ST_VOLTAGE_REGULATING_STATE] = plant.voltage_regulating_state; // [RQ13]
        stv[ST_CURRENT_REGULATING_STATE] = plant.current_regulating_state;
        stv[ST_POWER_REGULATING_STATE] = plant.power_regulating_state;
        stv[ST_RESISTANCE_REGULATING_STATE] = plant.resistance_regulating_state;
        stv[ST_LOCKED] = q.lock; // [RQ14]
        for (int k = 0; k < NUM_DOUT; k++) begin
            d.dout[k] = stv[dout_sel[k]]; // [RQ9] [RQ10]
        end

        // USB attach sync and edge
        d.usb_s1 = {host.rear_usb_attach, host.front_usb_attach};
        d.usb_s2 = q.usb_s1;
        d.usb_prev = q.usb_s2;
        f_rise = q.usb_s2[USB_FRONT_BIT] && !q.usb_prev[USB_FRONT_BIT];
        r_rise = q.usb_s2[USB_REAR_BIT] && !q.usb_prev[USB_REAR_BIT];

        // Same-cycle conflicts resolved by fixed priority, except GPIB keeps the bus over Ethernet while it owns it
        if (f_rise) begin
            d.owner = FRONT_USB_INDICATION; // [RQ16] [RQ17] [RQ21]
        end else if (r_rise) begin
            d.owner = REAR_USB_INDICATION; // [RQ17] [RQ21]
        end else if (host.eth_cmd && !(host.gpib_cmd && q.owner == GPIB_INDICATION)) begin
            d.owner = ETHERNET_INDICATION; // [RQ18]
        end else if (host.gpib_cmd) begin
            d.owner = GPIB_INDICATION; // [RQ18]
        end else begin
            // USB traffic alone never reclaims the bus
            case (q.owner)
                FRONT_USB_INDICATION: begin
                    if (!q.usb_s2[USB_FRONT_BIT]) begin
                        d.owner = RS485_INDICATION; // [RQ19] [RQ20]
                    end
                end
                REAR_USB_INDICATION: begin
                    if (!q.usb_s2[USB_REAR_BIT]) begin
                        d.owner = RS485_INDICATION; // [RQ20]
                    end
                end
                default: begin
                    d.owner = q.owner;
                end
            endcase
        end
        for (int p = 0; p < N_PORT; p++) begin
            d.grant[p] = (d.owner == uiohps_port_e'(p)); // [RQ15]
        end

        // Free-running so a frame can start on any tick
        if (q.baud_cnt == BAUD_CW'(BAUD_DIV - 1)) begin
            d.baud_cnt = '0;
            d.baud_tick = 1'b1; // [RQ22]
        end else begin
            d.baud_cnt = q.baud_cnt + 1'b1;
            d.baud_tick = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.grant <= GRANT_RST; // [RQ20]
        end else begin
            q <= d;
        end
    end

    assign dout_pin = q.dout;
    assign run_req = q.run;
    assign fault_latched = q.fault;
    assign interlock_trip = q.trip;
    assign panel_locked = q.lock;
    assign key_accept = q.key_acc;
    assign active_port = q.owner;
    assign port_grant = q.grant;
    assign rs485_bit_tick = q.baud_tick;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence front_attach_s;
        q.usb_s2[USB_FRONT_BIT] && !q.usb_prev[USB_FRONT_BIT];
    endsequence

    sequence rear_only_attach_s;
        q.usb_s2[USB_REAR_BIT] && !q.usb_prev[USB_REAR_BIT] && !f_rise;
    endsequence

    sequence no_usb_attach_s;
        !f_rise && !r_rise;
    endsequence

    stop_wins_a: assert property (stop_cmd |=> !run_req) // [RQ1]
        else $error("run request survived a stop");
    start_runs_a: assert property (start_cmd && !stop_ev && !q.fault && !d.trip
        && !fn_asg[FN_INPUT_ENABLE] |=> run_req) // [RQ2]
        else $error("start did not raise the run request");
    enable_follows_a: assert property (fn_asg[FN_INPUT_ENABLE] && !fn_lvl[FN_INPUT_ENABLE]
        |=> !run_req) // [RQ5]
        else $error("run request held with input enable low");
    trip_stops_a: assert property (d.trip |=> interlock_trip && fault_latched ##1 !run_req) // [RQ6]
        else $error("interlock loss did not stop and latch");
    clear_fault_a: assert property (fault_latched && fn_lvl[FN_CLEAR] && !flt_set
        |=> !fault_latched) // [RQ7]
        else $error("clear left a ceased fault latched");
    fault_holds_a: assert property (plant.fault_cond |=> fault_latched) // [RQ7]
        else $error("fault not latched while present");
    lock_keys_a: assert property (key_press && fn_lvl[FN_LOCK] |=> !key_accept && panel_locked) // [RQ8]
        else $error("key accepted while locked");
    out_sel_a: assert property (dout_sel[0] == ST_FAULT && $stable(dout_sel[0])
        |=> dout_pin[0] == $past(q.fault)) // [RQ9]
        else $error("status output does not follow its state");
    one_owner_a: assert property ($onehot(port_grant)
        && port_grant[active_port]) // [RQ15]
        else $error("bus grant not exactly the reported port");
    front_take_a: assert property (front_attach_s |=> active_port == FRONT_USB_INDICATION) // [RQ17]
        else $error("front attach did not take the bus");
    rear_take_a: assert property (rear_only_attach_s |=> active_port == REAR_USB_INDICATION) // [RQ21]
        else $error("rear attach did not take the bus");
    eth_take_a: assert property (no_usb_attach_s and host.eth_cmd && !host.gpib_cmd
        |=> active_port == ETHERNET_INDICATION) // [RQ18]
        else $error("Ethernet command did not take the bus");
    usb_no_return_a: assert property (no_usb_attach_s
        and (active_port != FRONT_USB_INDICATION && active_port != REAR_USB_INDICATION)
        |=> active_port != FRONT_USB_INDICATION && active_port != REAR_USB_INDICATION) // [RQ19]
        else $error("USB regained the bus without an attach");
    baud_rate_a: assert property (rs485_bit_tick |=> !rs485_bit_tick [*8]) // [RQ22]
        else $error("RS485 bit ticks too close together");

endmodule

// ==== uiohps_plc_model.sv ====
/*
 * External controller model: drives the four user input pins.
 * Assumes the bench sets want levels; a new high is held for at least
 * HOLD falling edges unless short_ok allows a deliberate short pulse.
 */
module uiohps_plc_model
    import uiohps_pkg::*;
#(
    parameter int unsigned HOLD = 8
) (
    // Clock
    input wire logic clk,
    // Wanted levels and glitch permission
    input wire logic [N_DIN-1:0] want,
    input wire logic [N_DIN-1:0] short_ok,
    // Pins
    output logic [N_DIN-1:0] din_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned cnt [N_DIN];

    initial begin
        din_pin = '0;
        foreach (cnt[i]) cnt[i] = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // A high is stretched to the minimum width; interlock level is held
    // as wanted, so its loss is a real trip
    // Short settle after the edge, so a want set on the same edge is seen
    always @(negedge clk) begin
        #1;
        for (int i = 0; i < N_DIN; i++) begin
            if (din_pin[i] && !want[i] && !short_ok[i] && cnt[i] < HOLD) begin
                cnt[i] <= cnt[i] + 1;
            end else begin
                din_pin[i] <= want[i];
                cnt[i] <= (want[i] != din_pin[i]) ? 1 : cnt[i] + 1;
            end
        end
    end
endmodule

// ==== user_io_and_host_port_select_tb.sv ====
/*
 * Self-checking bench for uiohps_top with a short filter count.
 * Assumes the controller model on the pins; host events and plant
 * levels are driven here on the falling edge.
 */
module user_io_and_host_port_select_tb;
    import uiohps_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned MINC = 8;
    localparam int unsigned FLT = MINC + 8;
    typedef struct packed {
        logic [31:0] sel;
        logic [5:0] pl;
        logic [7:0] exp;
    } uiohps_row_s;
    // Code 10 and 15 in the last row must read low
    localparam uiohps_row_s ROWS [6] = '{
        '{32'h8765_4321, 6'h20, 8'h01}, '{32'h8765_4321, 6'h28, 8'h11},
        '{32'h8765_4321, 6'h04, 8'h20}, '{32'h8765_4321, 6'h02, 8'h40},
        '{32'h8765_4321, 6'h01, 8'h80}, '{32'hFA90_1111, 6'h20, 8'h0F}};

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [N_DIN-1:0] want = '0;
    logic [N_DIN-1:0] short_ok = '0;
    logic [N_DIN-1:0] din_pin;
    logic [N_DOUT-1:0] dout_pin;
    uiohps_fn_e [N_DIN-1:0] din_fn = {FN_LOCK, FN_CLEAR, FN_STOP, FN_START};
    uiohps_st_e [N_DOUT-1:0] dout_sel = '0;
    uiohps_plant_s plant = '0;
    uiohps_host_s host = '0;
    logic start_cmd = 1'b0;
    logic stop_cmd = 1'b0;
    logic key_press = 1'b0;
    logic run_req, fault_latched, interlock_trip, panel_locked, key_accept;
    logic rs485_bit_tick;
    uiohps_port_e active_port;
    logic [N_PORT-1:0] port_grant;
    int failures = 0;
    int total_checks = 0;
    int n;

    always #10 clk = ~clk;

    uiohps_plc_model #(.HOLD(MINC)) plc_u (.clk(clk), .want(want), .short_ok(short_ok),
        .din_pin(din_pin));

    uiohps_top #(.MIN_CYC(MINC)) dut_u (.clk(clk), .nrst(nrst), .din_pin(din_pin),
        .dout_pin(dout_pin), .din_fn(din_fn), .dout_sel(dout_sel), .plant(plant),
        .start_cmd(start_cmd), .stop_cmd(stop_cmd), .run_req(run_req),
        .fault_latched(fault_latched), .interlock_trip(interlock_trip),
        .panel_locked(panel_locked), .key_press(key_press), .key_accept(key_accept),
        .host(host), .active_port(active_port), .port_grant(port_grant),
        .rs485_bit_tick(rs485_bit_tick));

    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int unsigned c);
        repeat (c) @(negedge clk);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic port(input uiohps_port_e exp);
        chk(active_port, exp);
        chk(port_grant, 5'h01 << exp);
    endtask

    task automatic pulse(ref logic s, input int unsigned wait_c);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(wait_c);
    endtask

    task automatic finish_test();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        step(5);
        nrst = 1'b1;
        step(1);
        port(RS485_INDICATION);
        chk(run_req, 1'b0);
        // Bit tick spacing, bounded waits
        n = 0;
        while (rs485_bit_tick !== 1'b1 && n < 1000) begin step(1); n++; end
        chk(n < 1000, 1'b1);
        step(1);
        n = 1;
        while (rs485_bit_tick !== 1'b1 && n < 1000) begin step(1); n++; end
        chk(n, BAUD_DIV);
        pulse(start_cmd, 1);
        chk(run_req, 1'b1);
        foreach (ROWS[r]) begin
            for (int k = 0; k < N_DOUT; k++) dout_sel[k] = uiohps_st_e'(ROWS[r].sel[4*k+:4]);
            plant = uiohps_plant_s'(ROWS[r].pl);
            step(3);
            chk(dout_pin, ROWS[r].exp);
        end
        // Stop beats start in the same cycle
        start_cmd = 1'b1;
        stop_cmd = 1'b1;
        step(1);
        start_cmd = 1'b0;
        stop_cmd = 1'b0;
        step(1);
        chk(run_req, 1'b0);
        for (int k = 0; k < N_DOUT; k++) dout_sel[k] = uiohps_st_e'(ROWS[0].sel[4*k+:4]);
        step(3);
        chk(dout_pin[2:0], 3'h6);
        // Short high must not start; a full one must, and only on the edge
        short_ok[0] = 1'b1;
        want[0] = 1'b1;
        step(MINC - 4);
        want[0] = 1'b0;
        step(FLT);
        chk(run_req, 1'b0);
        short_ok[0] = 1'b0;
        want[0] = 1'b1;
        step(FLT);
        chk(run_req, 1'b1);
        want[0] = 1'b0;
        step(FLT);
        chk(run_req, 1'b1);
        want[1:0] = 2'h3;
        step(FLT);
        chk(run_req, 1'b0);
        want[1:0] = 2'h0;
        step(FLT);
        // Fault latches; clear works only once the cause is gone
        pulse(start_cmd, 1);
        dout_sel[0] = ST_FAULT;
        plant = uiohps_plant_s'(6'h10);
        step(3);
        chk({fault_latched, run_req, dout_pin[3], dout_pin[1], dout_pin[0]}, 5'h17);
        want[2] = 1'b1;
        step(FLT);
        chk(fault_latched, 1'b1);
        plant = '0;
        step(2);
        chk({fault_latched, dout_pin[0]}, 2'h0);
        want[2] = 1'b0;
        // Lock blocks keys and shows on an output
        dout_sel[7] = ST_LOCKED;
        want[3] = 1'b1;
        step(FLT);
        chk({panel_locked, dout_pin[7]}, 2'h3);
        pulse(key_press, 0);
        chk(key_accept, 1'b0);
        want[3] = 1'b0;
        step(FLT);
        pulse(key_press, 0);
        chk(key_accept, 1'b1);
        step(1);
        chk(key_accept, 1'b0);
        // Interlock held high is normal; its loss trips and faults
        want[1] = 1'b1;
        step(FLT);
        din_fn[1] = FN_INTERLOCK;
        step(2);
        pulse(start_cmd, 1);
        chk({interlock_trip, run_req}, 2'h1);
        want[1] = 1'b0;
        step(FLT);
        chk({interlock_trip, fault_latched, run_req}, 3'h6);
        want[1] = 1'b1;
        want[2] = 1'b1;
        step(FLT);
        chk({interlock_trip, fault_latched}, 2'h0);
        want[2] = 1'b0;
        // Single-line run control
        din_fn[0] = FN_INPUT_ENABLE;
        want[0] = 1'b1;
        step(FLT);
        chk(run_req, 1'b1);
        want[0] = 1'b0;
        step(FLT);
        chk(run_req, 1'b0);
        pulse(start_cmd, 1);
        chk(run_req, 1'b0);
        // Host port ownership; struct members are driven inline, not by reference
        host.front_usb_attach = 1'b1;
        step(5);
        port(FRONT_USB_INDICATION);
        host.eth_cmd = 1'b1;
        step(1);
        host.eth_cmd = 1'b0;
        step(2);
        port(ETHERNET_INDICATION);
        step(5);
        port(ETHERNET_INDICATION);
        host.gpib_cmd = 1'b1;
        step(1);
        host.gpib_cmd = 1'b0;
        step(2);
        port(GPIB_INDICATION);
        host.rear_usb_attach = 1'b1;
        step(5);
        port(REAR_USB_INDICATION);
        host.front_usb_attach = 1'b0;
        step(5);
        port(REAR_USB_INDICATION);
        host.front_usb_attach = 1'b1;
        step(5);
        port(FRONT_USB_INDICATION);
        host = '0;
        step(5);
        port(RS485_INDICATION);
        host.front_usb_attach = 1'b1;
        host.rear_usb_attach = 1'b1;
        step(5);
        port(FRONT_USB_INDICATION);
        host.eth_cmd = 1'b1;
        host.gpib_cmd = 1'b1;
        step(1);
        host.eth_cmd = 1'b0;
        host.gpib_cmd = 1'b0;
        step(2);
        port(ETHERNET_INDICATION);
        // Reset in mid-run puts RS485 back in charge
        host = '0;
        nrst = 1'b0;
        step(2);
        port(RS485_INDICATION);
        chk(run_req, 1'b0);
        nrst = 1'b1;
        step(2);
        port(RS485_INDICATION);
        finish_test();
    end
endmodule
